// ---- design/sdi_pkg.sv ----
// Package for the strobed digital input event card: constants, offsets and carrier types
package sdi_pkg;
   // Geometry
   localparam int unsigned FIELD_W    = 16;
   localparam int unsigned NUM_FIELDS = 2;
   // Clock and timing
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned SAMPLE_NS       = 16_000;   // Event sample period, 16 us
   localparam int unsigned SAMPLE_CYC      = (SAMPLE_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned EXT_DLY_MIN_NS  = 2_000;    // Strobe to capture, least 2 us
   localparam int unsigned EXT_DLY_MIN_CYC = (EXT_DLY_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned READ_TIME_NS    = 42_000;   // Constant field read period
   localparam int unsigned READ_TIME_CYC   = (READ_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   // Register offsets (8-bit address)
   localparam logic [7:0] ADDR_POINTS   = 8'h00; // Captured states, both fields
   localparam logic [7:0] ADDR_FIELD1   = 8'h04; // Captured field 1
   localparam logic [7:0] ADDR_FIELD2   = 8'h08; // Captured field 2
   localparam logic [7:0] ADDR_STATUS   = 8'h0C; // Wait-for-strobe and busy
   localparam logic [7:0] ADDR_CONFIG   = 8'h10; // Strobe mode and polarity
   localparam logic [7:0] ADDR_SENSE    = 8'h14;
   localparam logic [7:0] ADDR_OVERRIDE = 8'h18;
   localparam logic [7:0] ADDR_UNMASK   = 8'h1C;
   localparam logic [7:0] ADDR_IRQREC   = 8'h20; // Read clears
   localparam logic [7:0] ADDR_IRQEN    = 8'h24;
   localparam logic [7:0] ADDR_CMD      = 8'h28; // Write: measurement strobe / read
   // Config fields
   localparam int unsigned CFG_EXT_LSB = 0;
   localparam int unsigned CFG_POL_LSB = 8;
   // Command fields
   localparam int unsigned CMD_STROBE_LSB = 0;  // Bits 1:0, measurement strobe per field
   localparam int unsigned CMD_READ_LSB   = 4;  // Bits 5:4, read request per field
   // Reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0]  RST_WAIT = 2'h3;

   // Register bus carrier
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sdi_bus_t;

   // Per-field read sequencer
   typedef enum logic [0:0] {RD_IDLE, RD_BUSY} sdi_rd_state_t;
endpackage

// ---- design/sdi_card.sv ----
// Strobed 32-point digital input card with transition event detection
// How it works
// R01 - 32 points, two 16-point fields, two strobes
// R02 - Strobe source chosen separately per field
// R03 - Capture fills point and field holding registers
// R04 - Level at strobe becomes stored state
// R05 - External strobe never touches event detection
// R06 - Events sampled every 16 us, undisturbed
// R07 - Measurement strobe with read, or deferred
// R08 - Status bit per field: waiting for strobe
// R09 - Unread data blocks new captures
// R10 - Compare previous and current sample
// R11 - Unmasked event sets record, raises interrupt
// R12 - Interrupt delivered only when enabled
// R13 - Record cleared by its read
// R14 - Capture 2 to 18 us after strobe
// R15 - Field read takes constant 42 us
// R16 - Sense one rising, zero falling
// R17 - Override accepts either direction
// R18 - Masked points record nothing
// R19 - Read-and-clear never loses events
// R20 - Free-running sample tick counter
// R21 - Two-stage synchronisers on strobes, points
`timescale 1ns/10ps
`default_nettype none
module sdi_card
   import sdi_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,    // Event sample period in clocks
   parameter int unsigned READ_CYCLES   = READ_TIME_CYC  // Constant field read time in clocks
) (
   // Clock and reset
   input  wire logic                              clk_sys_in,
   input  wire logic                              nrst_in,
   // Register port
   input  wire logic [7:0]                        addr_in,
   input  wire logic [31:0]                       wdata_in,
   input  wire logic                              wr_in,
   input  wire logic                              rd_in,
   output logic      [31:0]                       rdata_out,
   // Field pins
   input  wire logic [NUM_FIELDS*FIELD_W-1:0]     point_in,
   input  wire logic [NUM_FIELDS-1:0]             ext_strobe_in,
   // Backplane interrupt and read done
   output logic                                   irq_out,
   output logic [NUM_FIELDS-1:0]                  read_done_out
);
   localparam int unsigned NP = NUM_FIELDS * FIELD_W; // [R01]
   // The delay counter must hold the whole 2 us count; a narrow one wraps and captures early
   localparam int unsigned EXT_CW = $clog2(EXT_DLY_MIN_CYC + 1);

   // Bus carrier
   sdi_bus_t bus;
   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   // Synchronisers: stage one feeds stage two only
   logic [NP-1:0]         pt_s1_q, pt_s2_q;
   logic [NUM_FIELDS-1:0] st_s1_q, st_s2_q, st_prev_q;

   // Software registers
   logic [NUM_FIELDS-1:0] ext_mode_q;        // 1 = external strobe
   logic [NUM_FIELDS-1:0] ext_pol_q;         // 1 = rising edge
   logic [NP-1:0]         sense_q;
   logic [NP-1:0]         override_q;
   logic [NP-1:0]         unmask_q;
   logic                  irq_en_q;

   // Capture path
   logic [NP-1:0]         hold_pt_q;         // Point format holding register
   logic [NP-1:0]         hold_fld_q;        // Field format holding register
   logic [NUM_FIELDS-1:0] wait_q;            // Waiting for strobe
   logic [NUM_FIELDS-1:0] ext_pend_q;        // External edge seen, capture delayed
   logic [EXT_CW-1:0]     ext_cnt_q [NUM_FIELDS];

   // Event path
   logic [15:0]           tick_cnt_q;
   logic                  tick_q;
   logic [NP-1:0]         past_q;
   logic                  past_vld_q;
   logic [NP-1:0]         irq_rec_q;
   logic                  irq_ff_q;

   // Read sequencer
   sdi_rd_state_t         rd_st_q [NUM_FIELDS];
   logic [15:0]           rd_cnt_q [NUM_FIELDS];
   logic [NUM_FIELDS-1:0] read_done_q;

   // Qualify one transition per point
   function automatic logic [NP-1:0] evt_f(input logic [NP-1:0] past, input logic [NP-1:0] now,
                                           input logic [NP-1:0] sns, input logic [NP-1:0] ovr);
      evt_f = (past ^ now) & (ovr | ~(now ^ sns)); // [R10] [R16] [R17]
   endfunction

   // Field slice of a 32-bit value
   function automatic logic [FIELD_W-1:0] fld_f(input logic [NP-1:0] v, input int unsigned f);
      fld_f = v[f*FIELD_W +: FIELD_W];
   endfunction

   // Decoding
   wire        wr_cfg   = bus.wr && (bus.addr == ADDR_CONFIG);
   wire        wr_sense = bus.wr && (bus.addr == ADDR_SENSE);
   wire        wr_ovr   = bus.wr && (bus.addr == ADDR_OVERRIDE);
   wire        wr_unm   = bus.wr && (bus.addr == ADDR_UNMASK);
   wire        wr_ien   = bus.wr && (bus.addr == ADDR_IRQEN);
   wire        wr_cmd   = bus.wr && (bus.addr == ADDR_CMD);
   wire        rd_rec   = bus.rd && (bus.addr == ADDR_IRQREC);
   wire        rd_pts   = bus.rd && (bus.addr == ADDR_POINTS);
   wire [NUM_FIELDS-1:0] cmd_strobe = wr_cmd ? bus.wdata[CMD_STROBE_LSB +: NUM_FIELDS] : '0;
   wire [NUM_FIELDS-1:0] cmd_read   = wr_cmd ? bus.wdata[CMD_READ_LSB +: NUM_FIELDS] : '0;
   wire [NUM_FIELDS-1:0] rd_fld     = {bus.rd && (bus.addr == ADDR_FIELD2),
                                       bus.rd && (bus.addr == ADDR_FIELD1)};

   // Edge of external strobe in selected polarity
   wire [NUM_FIELDS-1:0] st_rise = st_s2_q & ~st_prev_q;
   wire [NUM_FIELDS-1:0] st_fall = ~st_s2_q & st_prev_q;
   wire [NUM_FIELDS-1:0] st_edge = (ext_pol_q & st_rise) | (~ext_pol_q & st_fall);

   // Capture strobe per field: internal or delayed external, source per field
   logic [NUM_FIELDS-1:0] cap;
   always_comb begin
      for (int f = 0; f < NUM_FIELDS; f++) begin
         if (ext_mode_q[f]) begin // [R02]
            cap[f] = ext_pend_q[f] && (ext_cnt_q[f] == EXT_CW'(EXT_DLY_MIN_CYC - 1)); // [R14]
         end else begin
            cap[f] = cmd_strobe[f]; // [R07]
         end
      end
   end
   wire [NUM_FIELDS-1:0] cap_ok = cap & wait_q; // [R09]

   // Data read consumes a field: a point read empties both
   wire [NUM_FIELDS-1:0] consumed = read_done_q;

   // Event path
   wire [NP-1:0] evt     = (tick_q && past_vld_q) ? evt_f(past_q, pt_s2_q, sense_q, override_q) : '0;
   wire [NP-1:0] evt_unm = evt & unmask_q; // [R18]
   wire [NP-1:0] rec_now = irq_rec_q | evt_unm;

   // Read data mux
   logic [31:0] rd_mux;
   always_comb begin
      case (bus.addr)
         ADDR_POINTS:   rd_mux = hold_pt_q; // [R03]
         ADDR_FIELD1:   rd_mux = {16'h0000, fld_f(hold_fld_q, 0)};
         ADDR_FIELD2:   rd_mux = {16'h0000, fld_f(hold_fld_q, 1)};
         ADDR_STATUS:   rd_mux = {28'h000_0000, (rd_st_q[1] == RD_BUSY), (rd_st_q[0] == RD_BUSY), wait_q}; // [R08]
         ADDR_CONFIG:   rd_mux = {22'h00_0000, ext_pol_q, 6'h00, ext_mode_q};
         ADDR_SENSE:    rd_mux = sense_q;
         ADDR_OVERRIDE: rd_mux = override_q;
         ADDR_UNMASK:   rd_mux = unmask_q;
         ADDR_IRQREC:   rd_mux = rec_now; // [R19]
         ADDR_IRQEN:    rd_mux = {31'h0000_0000, irq_en_q};
         default:       rd_mux = RST_WORD;
      endcase
   end

   // Synchronisers
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pt_s1_q   <= '0;
         pt_s2_q   <= '0;
         st_s1_q   <= '0;
         st_s2_q   <= '0;
         st_prev_q <= '0;
      end else begin
         pt_s1_q   <= point_in; // [R21]
         pt_s2_q   <= pt_s1_q;
         st_s1_q   <= ext_strobe_in;
         st_s2_q   <= st_s1_q;
         st_prev_q <= st_s2_q;
      end
   end

   // Software written registers
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ext_mode_q <= '0;
         ext_pol_q  <= '0;
         sense_q    <= RST_WORD;
         override_q <= RST_WORD;
         unmask_q   <= RST_WORD;
         irq_en_q   <= 1'b0;
      end else begin
         if (wr_cfg) begin
            ext_mode_q <= bus.wdata[CFG_EXT_LSB +: NUM_FIELDS];
            ext_pol_q  <= bus.wdata[CFG_POL_LSB +: NUM_FIELDS];
         end
         if (wr_sense) sense_q    <= bus.wdata;
         if (wr_ovr)   override_q <= bus.wdata;
         if (wr_unm)   unmask_q   <= bus.wdata;
         if (wr_ien)   irq_en_q   <= bus.wdata[0];
      end
   end

   // Capture, wait flag and external delay per field
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         hold_pt_q  <= '0;
         hold_fld_q <= '0;
         wait_q     <= RST_WAIT;
         ext_pend_q <= '0;
         for (int f = 0; f < NUM_FIELDS; f++) ext_cnt_q[f] <= '0;
      end else begin
         for (int f = 0; f < NUM_FIELDS; f++) begin
            // Delay external edge; edges during delay ignored (rate bounded outside)
            if (ext_mode_q[f] && st_edge[f] && !ext_pend_q[f]) begin // [R14]
               ext_pend_q[f] <= 1'b1;
               ext_cnt_q[f]  <= '0;
            end else if (ext_pend_q[f]) begin
               ext_cnt_q[f]  <= ext_cnt_q[f] + EXT_CW'(1);
               if (cap[f]) ext_pend_q[f] <= 1'b0;
            end
            if (cap_ok[f]) begin
               hold_pt_q[f*FIELD_W +: FIELD_W]  <= fld_f(pt_s2_q, f); // [R03] [R04]
               hold_fld_q[f*FIELD_W +: FIELD_W] <= fld_f(pt_s2_q, f);
               wait_q[f] <= 1'b0; // [R09]
            end else if (consumed[f]) begin
               wait_q[f] <= 1'b1; // [R08]
            end
         end
      end
   end

   // Read sequencer: fixed period from request to done
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         read_done_q <= '0;
         for (int f = 0; f < NUM_FIELDS; f++) begin
            rd_st_q[f]  <= RD_IDLE;
            rd_cnt_q[f] <= '0;
         end
      end else begin
         for (int f = 0; f < NUM_FIELDS; f++) begin
            read_done_q[f] <= 1'b0;
            case (rd_st_q[f])
               RD_IDLE: begin
                  if (cmd_read[f] || rd_fld[f] || rd_pts) begin
                     rd_st_q[f]  <= RD_BUSY;
                     rd_cnt_q[f] <= '0;
                  end
               end
               RD_BUSY: begin
                  if (rd_cnt_q[f] == 16'(READ_CYCLES - 1)) begin // [R15]
                     rd_st_q[f]     <= RD_IDLE;
                     read_done_q[f] <= 1'b1;
                  end else begin
                     rd_cnt_q[f] <= rd_cnt_q[f] + 16'd1;
                  end
               end
               default: rd_st_q[f] <= RD_IDLE;
            endcase
         end
      end
   end

   // Free-running sample tick; nothing on the bus can stall it
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tick_cnt_q <= '0;
         tick_q     <= 1'b0;
      end else begin
         tick_q     <= (tick_cnt_q == 16'(SAMPLE_CYCLES - 1)); // [R20] [R06]
         tick_cnt_q <= (tick_cnt_q == 16'(SAMPLE_CYCLES - 1)) ? '0 : tick_cnt_q + 16'd1;
      end
   end

   // Event detection on raw points, independent of strobes
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         past_q     <= '0;
         past_vld_q <= 1'b0;
         irq_rec_q  <= '0;
         irq_ff_q   <= 1'b0;
      end else begin
         if (tick_q) begin
            past_q     <= pt_s2_q; // [R05] [R06]
            past_vld_q <= 1'b1;
         end
         // Read returns rec_now, so only events after this cycle remain
         if (rd_rec) begin
            irq_rec_q <= '0; // [R13] [R19]
            irq_ff_q  <= 1'b0;
         end else begin
            irq_rec_q <= rec_now; // [R11]
            if ((evt_unm & ~irq_rec_q) != '0) irq_ff_q <= 1'b1;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out     <= '0;
         irq_out       <= 1'b0;
         read_done_out <= '0;
      end else begin
         rdata_out     <= rd_mux;
         irq_out       <= irq_ff_q && irq_en_q && !rd_rec; // [R12]
         read_done_out <= read_done_q;
      end
   end
endmodule
`default_nettype wire

// ---- verif/sdi_card_sva.sv ----
// Port-level assertion checker for the strobed digital input card
`timescale 1ns/10ps
`default_nettype none
module sdi_card_sva
   import sdi_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,   // Event sample period in clocks
   parameter int unsigned READ_CYCLES   = READ_TIME_CYC // Field read period in clocks
) (
   // Clock and reset
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   // Register port
   input wire logic [7:0]  addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [31:0] rdata_out,
   // Field pins and backplane
   input wire logic [31:0] point_in,
   input wire logic [1:0]  ext_strobe_in,
   input wire logic        irq_out,
   input wire logic [1:0]  read_done_out
);
   logic      en_q;                                  // Shadow of the interrupt enable bit
   wire logic rec_rd = rd_in && addr_in == ADDR_IRQREC; // Record read taken this edge
   // Shadow follows enable writes; irq_out lags it by one register stage
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_q <= 1'b0;
      end else if (wr_in && addr_in == ADDR_IRQEN) begin
         en_q <= wdata_in[0];
      end
   end
   // Shadow of each field's read sequencer: a request is taken only while that field is idle
   wire logic       pts_rd  = rd_in && addr_in == ADDR_POINTS;
   wire logic       cmd_wr  = wr_in && addr_in == ADDR_CMD;
   wire logic       rd_f1   = rd_in && addr_in == ADDR_FIELD1;
   wire logic       rd_f2   = rd_in && addr_in == ADDR_FIELD2;
   wire logic [1:0] fld_req = {pts_rd || rd_f2 || (cmd_wr && wdata_in[CMD_READ_LSB + 1]),
                               pts_rd || rd_f1 || (cmd_wr && wdata_in[CMD_READ_LSB])};
   logic [1:0]      sh_busy_q;     // Field read period running
   logic [15:0]     sh_age_q [2];  // Cycles since the taken request
   // Counter instead of a long delay, so the default period needs no huge delay range
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sh_busy_q   <= '0;
         sh_age_q[0] <= '0;
         sh_age_q[1] <= '0;
      end else begin
         for (int f = 0; f < 2; f++) begin
            if (!sh_busy_q[f]) begin
               sh_busy_q[f] <= fld_req[f];
               sh_age_q[f]  <= '0;
            end else if (sh_age_q[f] == 16'(READ_CYCLES - 1)) begin
               sh_busy_q[f] <= 1'b0;
            end else begin
               sh_age_q[f]  <= sh_age_q[f] + 16'd1;
            end
         end
      end
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   a_done1_pulse: assert property (read_done_out[0] |=> !read_done_out[0])
      else $error("field 1 read done wider than one cycle");
   a_done2_pulse: assert property (read_done_out[1] |=> !read_done_out[1])
      else $error("field 2 read done wider than one cycle");
   a_read1_time: assert property (sh_busy_q[0] && sh_age_q[0] == 16'(READ_CYCLES - 1) |-> ##2 read_done_out[0])
      else $error("field 1 read period wrong");
   a_read2_time: assert property (sh_busy_q[1] && sh_age_q[1] == 16'(READ_CYCLES - 1) |-> ##2 read_done_out[1])
      else $error("field 2 read period wrong");
   a_field_width: assert property (rd_in && (addr_in == ADDR_FIELD1 || addr_in == ADDR_FIELD2) |=> rdata_out[31:16] == 16'h0000)
      else $error("field read wider than 16 points");
   a_status_bits: assert property (rd_in && addr_in == ADDR_STATUS |=> rdata_out[31:4] == 28'h000_0000)
      else $error("status read has stray bits");
   a_irq_gated: assert property (!en_q && !$past(en_q) |-> !irq_out)
      else $error("interrupt delivered while disabled");
   a_irq_held: assert property (irq_out && !rec_rd && !$past(rec_rd) && en_q && $past(en_q) |=> irq_out)
      else $error("interrupt dropped without a record read");
endmodule
bind sdi_card sdi_card_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES), .READ_CYCLES(READ_CYCLES)) sdi_card_sva_i (
   .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
   .rd_in(rd_in), .rdata_out(rdata_out), .point_in(point_in), .ext_strobe_in(ext_strobe_in),
   .irq_out(irq_out), .read_done_out(read_done_out));
`default_nettype wire

// ---- verif/sdi_host.sv ----
// Processor-side model: drives the card register port one strobe at a time
`timescale 1ns/10ps
`default_nettype none
module sdi_host
   import sdi_pkg::*;
(
   // Clock
   input  wire logic        clk_sys_in,
   // Register port toward the card
   output var sdi_bus_t     bus_out,
   input  wire logic [31:0] rdata_in
);
   // Idle bus from time zero so the card never sees a stray strobe
   initial bus_out = '0;
   // One-cycle write; signals move only just after a rising edge
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_in);
      bus_out.wr <= 1'b0;
   endtask
   // One-cycle read; data is only meaningful in the following cycle
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      bus_out <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_in);
      bus_out.rd <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule
`default_nettype wire

// ---- verif/sdi_card_tb.sv ----
// Self-checking bench for the strobed digital input card
`timescale 1ns/10ps
`default_nettype none
module sdi_card_tb;
   import sdi_pkg::*;
   logic             clk_sys_in    = 1'b0;  // 40 MHz system clock
   logic             nrst_in       = 1'b0;  // Active-low reset
   logic [31:0]      point_in      = '0;    // Field inputs
   logic [1:0]       ext_strobe_in = '0;    // External strobes
   sdi_bus_t         bus;                   // Register port from the host model
   wire logic [31:0] rdata_out;
   wire logic        irq_out;
   wire logic [1:0]  read_done_out;
   int               fails         = 0;     // Mismatches seen
   int               check_count   = 0;     // Comparisons made
   logic [31:0]      a_v, b_v, sns, ovr, unm, exp_v, d;
   logic             en;
   // Short periods keep the run brief; expectations follow these values
   sdi_card #(.SAMPLE_CYCLES(8), .READ_CYCLES(4)) sdi_card_i (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(bus.addr), .wdata_in(bus.wdata),
      .wr_in(bus.wr), .rd_in(bus.rd), .rdata_out(rdata_out), .point_in(point_in),
      .ext_strobe_in(ext_strobe_in), .irq_out(irq_out), .read_done_out(read_done_out));
   sdi_host sdi_host_i (.clk_sys_in(clk_sys_in), .bus_out(bus), .rdata_in(rdata_out));
   // Free-running clock, 25 ns period
   initial begin
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] v;
      sdi_host_i.rd_reg(a, v);
      check(v, exp, what);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Event expected when changed and either override set or new level equals sense
   function automatic logic [31:0] ev_exp(input logic [31:0] p, n, s, o, u);
      return (p ^ n) & (o | ~(n ^ s)) & u;
   endfunction
   // Main sequence
   initial begin
      void'($urandom(32'h29d9));
      cyc(4);
      nrst_in <= 1'b1;
      rd_chk(ADDR_STATUS, {30'h0000_0000, RST_WAIT}, "status reset");
      rd_chk(ADDR_IRQREC, 32'h0000_0000, "record reset");
      // Internal strobe on both fields, then a refused second strobe
      a_v = $urandom();
      @(posedge clk_sys_in) point_in <= a_v;
      cyc(4);
      sdi_host_i.wr_reg(ADDR_CMD, 32'h0000_0003);
      rd_chk(ADDR_STATUS, 32'h0000_0000, "status after strobe");
      @(posedge clk_sys_in) point_in <= ~a_v;
      cyc(4);
      sdi_host_i.wr_reg(ADDR_CMD, 32'h0000_0003);
      rd_chk(ADDR_FIELD1, {16'h0000, a_v[15:0]}, "field 1");
      rd_chk(ADDR_FIELD2, {16'h0000, a_v[31:16]}, "field 2");
      rd_chk(ADDR_POINTS, a_v, "points");
      cyc(12);
      rd_chk(ADDR_STATUS, {30'h0000_0000, RST_WAIT}, "status after reads");
      // Read request without bus data: both sequencers show busy
      sdi_host_i.wr_reg(ADDR_CMD, 32'h0000_0030);
      rd_chk(ADDR_STATUS, 32'h0000_000F, "busy after read request");
      cyc(12);
      // Field 1 external rising strobe, field 2 internal strobe
      sdi_host_i.wr_reg(ADDR_CONFIG, 32'h0000_0101);
      b_v = $urandom();
      @(posedge clk_sys_in) point_in <= b_v;
      cyc(4);
      sdi_host_i.wr_reg(ADDR_CMD, 32'h0000_0002);
      // Single edge, far below the highest allowed strobe rate
      @(posedge clk_sys_in) ext_strobe_in[0] <= 1'b1;
      cyc(40);
      rd_chk(ADDR_STATUS, 32'h0000_0001, "ext capture early");
      cyc(60);
      rd_chk(ADDR_STATUS, 32'h0000_0000, "ext capture done");
      rd_chk(ADDR_FIELD1, {16'h0000, b_v[15:0]}, "ext field 1");
      rd_chk(ADDR_FIELD2, {16'h0000, b_v[31:16]}, "int field 2");
      sdi_host_i.wr_reg(ADDR_CONFIG, 32'h0000_0000);
      cyc(12);
      // Field 2 external falling strobe; its rising edge must not capture
      sdi_host_i.wr_reg(ADDR_CONFIG, 32'h0000_0002);
      @(posedge clk_sys_in) ext_strobe_in[1] <= 1'b1;
      b_v = $urandom();
      @(posedge clk_sys_in) point_in <= b_v;
      cyc(100);
      rd_chk(ADDR_STATUS, {30'h0000_0000, RST_WAIT}, "rise ignored in falling mode");
      @(posedge clk_sys_in) ext_strobe_in[1] <= 1'b0;
      cyc(100);
      rd_chk(ADDR_FIELD2, {16'h0000, b_v[31:16]}, "ext falling field 2");
      sdi_host_i.wr_reg(ADDR_CONFIG, 32'h0000_0000);
      cyc(12);
      // Event detection; first pass is all-change, override, unmasked, disabled
      for (int t = 0; t < 16; t++) begin
         a_v = $urandom();
         b_v = (t == 0) ? ~a_v : $urandom();
         sns = $urandom();
         ovr = (t == 0) ? '1 : $urandom();
         unm = (t == 0) ? '1 : $urandom();
         en = (t < 2) ? t[0] : 1'($urandom());
         sdi_host_i.wr_reg(ADDR_SENSE, sns);
         sdi_host_i.wr_reg(ADDR_OVERRIDE, ovr);
         sdi_host_i.wr_reg(ADDR_UNMASK, unm);
         sdi_host_i.wr_reg(ADDR_IRQEN, {31'h0000_0000, en});
         @(posedge clk_sys_in) point_in <= a_v;
         cyc(24);
         sdi_host_i.rd_reg(ADDR_IRQREC, d);
         @(posedge clk_sys_in) point_in <= b_v;
         cyc(24);
         exp_v = ev_exp(a_v, b_v, sns, ovr, unm);
         @(negedge clk_sys_in);
         check({31'h0000_0000, irq_out}, {31'h0000_0000, en && exp_v != 0}, "irq level");
         rd_chk(ADDR_IRQREC, exp_v, "record");
         cyc(3);
         @(negedge clk_sys_in);
         check({31'h0000_0000, irq_out}, 32'h0000_0000, "irq after clear");
         rd_chk(ADDR_IRQREC, 32'h0000_0000, "record cleared");
      end
      test_done();
   end
   // Watchdog cuts a hang short
   initial begin
      cyc(20000);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done();
   end
endmodule
`default_nettype wire
